//--- logic/ppfs_pkg.sv
package ppfs_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_PORT_MODE_REG_ONE = 8'h00;
  localparam logic [7:0] OFS_PORT_TWO_DIRECTION_REG = 8'h04;
  localparam logic [7:0] OFS_PORT_TWO_DATA_REG = 8'h08;
  localparam logic [7:0] OFS_SERIAL_CONTROL_REG = 8'h0C;
  localparam logic [7:0] OFS_SERIAL_MODE_REG = 8'h10;
  localparam logic [7:0] OFS_PORT_FIVE_MODE_REG = 8'h14;
  localparam logic [7:0] OFS_PORT_FIVE_DATA = 8'h18;
  // Field positions
  localparam int BIT_TX_SELECT = 1;
  localparam int BIT_RECEIVE_ENABLE = 4;
  localparam int BIT_CLOCK_SELECT_HI = 1;
  localparam int BIT_CLOCK_SELECT_LO = 0;
  localparam int BIT_COMM_MODE = 7;
  // Reset values, read constants and the NONSEQ transfer code
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [31:0] PDR_UPPER_ONES = 32'h0000_00F8;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  // Roles of one port two pin
  typedef struct packed {
    logic oe;
    logic out;
  } ppfs_drive_t;
endpackage : ppfs_pkg

//--- logic/ppfs_pin_decode.sv
`timescale 1ns/1ps
// Combinational role decode for the three shared port two pins
module ppfs_pin_decode
  import ppfs_pkg::*;
(
  input wire logic i_tx_sel,
  input wire logic i_rx_en,
  input wire logic i_cke_hi,
  input wire logic i_cke_lo,
  input wire logic i_comm_sync,
  input wire logic [2:0] i_dir,
  input wire logic [2:0] i_data,
  input wire logic i_txd,
  input wire logic i_sck_out,
  output ppfs_drive_t o_drv [3]
);
  // Pin two: transmit wins over direction bit
  always_comb
  begin
    if (i_tx_sel)
    begin
      o_drv[2] = '{oe: 1'b1, out: i_txd};
    end
    else
    begin
      o_drv[2] = '{oe: i_dir[2], out: i_data[2]};
    end
  end
  // Pin one: receive input wins over direction bit
  always_comb
  begin
    if (i_rx_en)
    begin
      o_drv[1] = '{oe: 1'b0, out: 1'b0};
    end
    else
    begin
      o_drv[1] = '{oe: i_dir[1], out: i_data[1]};
    end
  end
  // Pin zero: clock select first, then communication mode
  always_comb
  begin
    if (i_cke_hi)
    begin
      o_drv[0] = '{oe: 1'b0, out: 1'b0};
    end
    else if (i_cke_lo)
    begin
      o_drv[0] = '{oe: 1'b1, out: i_sck_out};
    end
    else if (i_comm_sync)
    begin
      o_drv[0] = '{oe: 1'b1, out: i_sck_out};
    end
    else
    begin
      o_drv[0] = '{oe: i_dir[0], out: i_data[0]};
    end
  end
endmodule : ppfs_pin_decode

//--- logic/ppfs_top.sv
`timescale 1ns/1ps
// Pin function select for port two and port five, AHB-Lite slave
module ppfs_top
  import ppfs_pkg::*;
(
  input wire logic I_REF_CLK,
  input wire logic I_RESET_N,
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  output logic [31:0] O_HRDATA,
  output logic O_HREADYOUT,
  output logic O_HRESP,
  input wire logic [2:0] I_PORT_TWO_PIN,
  output logic [2:0] O_PORT_TWO_PIN,
  output logic [2:0] O_PORT_TWO_PIN_OE,
  input wire logic I_TXD,
  input wire logic I_SCK_OUT,
  output logic O_RXD,
  output logic O_SCK_IN,
  output logic O_TX_SELECT,
  output logic O_RECEIVE_ENABLE,
  output logic [1:0] O_CLOCK_SELECT,
  output logic O_COMM_SYNC,
  input wire logic [7:2] I_PORT_FIVE_PIN,
  input wire logic [7:6] I_PORT_FIVE_OUT,
  input wire logic [7:6] I_PORT_FIVE_OUT_EN,
  output logic [7:6] O_PORT_FIVE_PIN,
  output logic [7:6] O_PORT_FIVE_PIN_OE,
  output logic [5:2] O_WAKEUP_INPUT,
  output logic O_ADC_EXTERNAL_TRIGGER
);
  logic [7:0] port_mode_reg_one; // Transmit select lives here
  logic [2:0] port_two_direction_reg; // Write-only direction bits
  logic [2:0] port_two_data_reg; // Output latch
  logic [7:0] serial_control_reg; // Receive enable and clock select
  logic [7:0] serial_mode_reg; // Communication mode
  logic [7:0] port_five_mode_reg; // Open-drain and wakeup selects
  logic wr_pend; // Write data phase pending
  logic [7:0] wr_addr; // Latched write address
  ppfs_drive_t drv [3]; // Decoded port two drives
  logic [31:0] next_rdata; // Read mux result
  logic take; // Valid address phase
  logic [2:0] p2_rd; // Port two read value

  assign take = I_HSEL && I_HREADY && (I_HTRANS == HTRANS_NONSEQ);

  // Shared pin role decoder
  ppfs_pin_decode u_decode (
    .i_tx_sel(port_mode_reg_one[BIT_TX_SELECT]),
    .i_rx_en(serial_control_reg[BIT_RECEIVE_ENABLE]),
    .i_cke_hi(serial_control_reg[BIT_CLOCK_SELECT_HI]),
    .i_cke_lo(serial_control_reg[BIT_CLOCK_SELECT_LO]),
    .i_comm_sync(serial_mode_reg[BIT_COMM_MODE]),
    .i_dir(port_two_direction_reg),
    .i_data(port_two_data_reg),
    .i_txd(I_TXD),
    .i_sck_out(I_SCK_OUT),
    .o_drv(drv)
  );

  // Bus write phase bookkeeping; always zero wait states
  always_ff @(posedge I_REF_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      wr_pend <= 1'b0;
      wr_addr <= RST_BYTE;
      O_HREADYOUT <= 1'b1;
      O_HRESP <= 1'b0;
    end
    else
    begin
      O_HREADYOUT <= 1'b1;
      // Every transfer answers OKAY
      O_HRESP <= 1'b0;
      wr_pend <= take && I_HWRITE;
      wr_addr <= I_HADDR[7:0];
    end
  end

  // Register writes in the data phase
  always_ff @(posedge I_REF_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      port_mode_reg_one <= RST_BYTE;
      port_two_direction_reg <= 3'h0;
      port_two_data_reg <= 3'h0;
      serial_control_reg <= RST_BYTE;
      serial_mode_reg <= RST_BYTE;
      port_five_mode_reg <= RST_BYTE;
    end
    else if (wr_pend)
    begin
      case (wr_addr)
        OFS_PORT_MODE_REG_ONE: port_mode_reg_one <= I_HWDATA[7:0];
        OFS_PORT_TWO_DIRECTION_REG: port_two_direction_reg <= I_HWDATA[2:0];
        OFS_PORT_TWO_DATA_REG: port_two_data_reg <= I_HWDATA[2:0];
        OFS_SERIAL_CONTROL_REG: serial_control_reg <= I_HWDATA[7:0];
        OFS_SERIAL_MODE_REG: serial_mode_reg <= I_HWDATA[7:0];
        OFS_PORT_FIVE_MODE_REG: port_five_mode_reg <= I_HWDATA[7:0];
        default: ;
      endcase
    end
  end

  // Data read: latch for outputs, live pin for inputs
  generate
    for (genvar g = 0; g < 3; g++)
    begin : g_p2rd
      assign p2_rd[g] = port_two_direction_reg[g] ? port_two_data_reg[g] : I_PORT_TWO_PIN[g];
    end
  endgenerate

  // Read mux; direction register reads zero
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    case (I_HADDR[7:0])
      OFS_PORT_MODE_REG_ONE: next_rdata = {24'h00_0000, port_mode_reg_one};
      OFS_PORT_TWO_DATA_REG: next_rdata = PDR_UPPER_ONES | {29'h0000_0000, p2_rd};
      OFS_SERIAL_CONTROL_REG: next_rdata = {24'h00_0000, serial_control_reg};
      OFS_SERIAL_MODE_REG: next_rdata = {24'h00_0000, serial_mode_reg};
      OFS_PORT_FIVE_MODE_REG: next_rdata = {24'h00_0000, port_five_mode_reg};
      OFS_PORT_FIVE_DATA: next_rdata = {24'h00_0000, I_PORT_FIVE_PIN, 2'h0};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // Read data register
  always_ff @(posedge I_REF_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      O_HRDATA <= 32'h0000_0000;
    end
    else if (take && !I_HWRITE)
    begin
      O_HRDATA <= next_rdata;
    end
  end

  // Port two pin and serial outputs, registered
  always_ff @(posedge I_REF_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      O_PORT_TWO_PIN <= 3'h0;
      O_PORT_TWO_PIN_OE <= 3'h0;
      O_RXD <= 1'b1;
      O_SCK_IN <= 1'b0;
      O_TX_SELECT <= 1'b0;
      O_RECEIVE_ENABLE <= 1'b0;
      O_CLOCK_SELECT <= 2'h0;
      O_COMM_SYNC <= 1'b0;
    end
    else
    begin
      for (int k = 0; k < 3; k++)
      begin
        O_PORT_TWO_PIN[k] <= drv[k].out;
        O_PORT_TWO_PIN_OE[k] <= drv[k].oe;
      end
      O_RXD <= serial_control_reg[BIT_RECEIVE_ENABLE] ? I_PORT_TWO_PIN[1] : 1'b1;
      O_SCK_IN <= serial_control_reg[BIT_CLOCK_SELECT_HI] ? I_PORT_TWO_PIN[0] : 1'b0;
      O_TX_SELECT <= port_mode_reg_one[BIT_TX_SELECT];
      O_RECEIVE_ENABLE <= serial_control_reg[BIT_RECEIVE_ENABLE];
      O_CLOCK_SELECT <= serial_control_reg[1:0];
      O_COMM_SYNC <= serial_mode_reg[BIT_COMM_MODE];
    end
  end

  // Port five open-drain and wakeup routing
  always_ff @(posedge I_REF_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      O_PORT_FIVE_PIN <= 2'h0;
      O_PORT_FIVE_PIN_OE <= 2'h0;
      O_WAKEUP_INPUT <= 4'h0;
      O_ADC_EXTERNAL_TRIGGER <= 1'b0;
    end
    else
    begin
      for (int k = 6; k < 8; k++)
      begin
        if (port_five_mode_reg[k])
        begin
          // Open drain: drive only a low, release for high
          O_PORT_FIVE_PIN[k] <= 1'b0;
          O_PORT_FIVE_PIN_OE[k] <= I_PORT_FIVE_OUT_EN[k] && !I_PORT_FIVE_OUT[k];
        end
        else
        begin
          O_PORT_FIVE_PIN[k] <= I_PORT_FIVE_OUT[k];
          O_PORT_FIVE_PIN_OE[k] <= I_PORT_FIVE_OUT_EN[k];
        end
      end
      for (int k = 2; k < 6; k++)
      begin
        O_WAKEUP_INPUT[k] <= port_five_mode_reg[k] && I_PORT_FIVE_PIN[k];
      end
      O_ADC_EXTERNAL_TRIGGER <= port_five_mode_reg[5] && I_PORT_FIVE_PIN[5];
    end
  end
endmodule : ppfs_top

//--- sim/ppfs_far_side.sv
`timescale 1ns/1ps
// Board side of the three shared pins
module ppfs_far_side
(
  input wire logic [2:0] i_oe,
  input wire logic [2:0] i_drv,
  input wire logic [2:0] i_board,
  output logic [2:0] o_pin
);
  // Block drives where enabled, the board elsewhere
  assign o_pin = (i_oe & i_drv) | (~i_oe & i_board);
endmodule : ppfs_far_side

//--- sim/ppfs_top_asserts.sv
`timescale 1ns/1ps
// Pin routing checks at the block ports
module ppfs_top_asserts
(
  input wire logic I_REF_CLK,
  input wire logic I_RESET_N,
  input wire logic [2:0] I_PORT_TWO_PIN,
  input wire logic I_TXD,
  input wire logic I_SCK_OUT,
  input wire logic [7:2] I_PORT_FIVE_PIN,
  input wire logic [7:6] I_PORT_FIVE_OUT,
  input wire logic [7:6] I_PORT_FIVE_OUT_EN,
  input wire logic [2:0] O_PORT_TWO_PIN,
  input wire logic [2:0] O_PORT_TWO_PIN_OE,
  input wire logic O_RXD,
  input wire logic O_TX_SELECT,
  input wire logic O_RECEIVE_ENABLE,
  input wire logic [1:0] O_CLOCK_SELECT,
  input wire logic O_COMM_SYNC,
  input wire logic [7:6] O_PORT_FIVE_PIN,
  input wire logic [7:6] O_PORT_FIVE_PIN_OE,
  input wire logic [5:2] O_WAKEUP_INPUT,
  input wire logic O_ADC_EXTERNAL_TRIGGER
);
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RESET_N);
  // Settings held two cycles so the registered pins have caught up
  a_tx_pin_drive:
    assert property (O_TX_SELECT && $past(O_TX_SELECT) |-> O_PORT_TWO_PIN_OE[2] && O_PORT_TWO_PIN[2] == $past(I_TXD))
      else $error("tx pin");
  a_rx_pin_route:
    assert property (O_RECEIVE_ENABLE && $past(O_RECEIVE_ENABLE) |-> !O_PORT_TWO_PIN_OE[1] && O_RXD == $past(I_PORT_TWO_PIN[1]))
      else $error("rx pin");
  a_sck_in_pin:
    assert property (O_CLOCK_SELECT[1] && $past(O_CLOCK_SELECT[1]) |-> !O_PORT_TWO_PIN_OE[0])
      else $error("clock in");
  a_sck_out_lo:
    assert property ($stable({O_CLOCK_SELECT, O_COMM_SYNC}) && O_CLOCK_SELECT == 2'h1 |-> O_PORT_TWO_PIN_OE[0] && O_PORT_TWO_PIN[0] == $past(I_SCK_OUT))
      else $error("clock out");
  a_sck_out_sync:
    assert property ($stable({O_CLOCK_SELECT, O_COMM_SYNC}) && O_CLOCK_SELECT == 2'h0 && O_COMM_SYNC |-> O_PORT_TWO_PIN_OE[0] && O_PORT_TWO_PIN[0] == $past(I_SCK_OUT))
      else $error("sync clock");
  a_five_drive:
    assert property ((O_PORT_FIVE_PIN_OE & ~(O_PORT_FIVE_PIN ^ $past(I_PORT_FIVE_OUT)) & $past(I_PORT_FIVE_OUT_EN)) == O_PORT_FIVE_PIN_OE)
      else $error("port five drive");
  a_five_od_release:
    assert property (((O_PORT_FIVE_PIN ^ O_PORT_FIVE_PIN_OE) & $past(I_PORT_FIVE_OUT_EN) & $past(I_PORT_FIVE_OUT)) == 2'h0)
      else $error("port five release");
  a_wake_gate:
    assert property ((O_WAKEUP_INPUT & ~$past(I_PORT_FIVE_PIN[5:2])) == 4'h0)
      else $error("wakeup");
  a_adc_trigger:
    assert property (O_ADC_EXTERNAL_TRIGGER == O_WAKEUP_INPUT[5])
      else $error("trigger");
endmodule : ppfs_top_asserts

bind ppfs_top ppfs_top_asserts u_chk (.*);

//--- sim/tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; $display("unexpected %0t %h %h", $time, g, e); end end
// Register driven pin role bench
module tb
  import ppfs_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic hready, txd = 1'b0, sck = 1'b1, rxd, sck_in, csync, adc;
  logic [2:0] board = 3'h5;
  logic [2:0] pin2, drv2, oe2;
  logic [1:0] csel;
  logic txsel, rxen, hresp;
  logic [7:2] p5pin = 6'h2D;
  logic [7:6] p5out = 2'h2;
  logic [7:6] p5en = 2'h3;
  logic [7:6] p5drv, p5oe;
  logic [5:2] wake;
  // Every mode and control register, the direction register and an unmapped place, all zero after reset
  logic [7:0] regs [6] = '{OFS_PORT_MODE_REG_ONE, OFS_PORT_TWO_DIRECTION_REG, OFS_SERIAL_CONTROL_REG,
    OFS_SERIAL_MODE_REG, OFS_PORT_FIVE_MODE_REG, 8'h40};
  int err_total = 0;
  int n_tests = 0;
  // Half period of a 200 MHz clock
  always #2.5 clk = ~clk;
  ppfs_top DUT (.I_REF_CLK(clk), .I_RESET_N(rst_n), .I_HSEL(1'b1), .I_HADDR(haddr), .I_HTRANS(htrans),
    .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hready), .O_HRDATA(hrdata),
    .O_HREADYOUT(hready), .O_HRESP(hresp), .I_PORT_TWO_PIN(pin2), .O_PORT_TWO_PIN(drv2), .O_PORT_TWO_PIN_OE(oe2),
    .I_TXD(txd), .I_SCK_OUT(sck), .O_RXD(rxd), .O_SCK_IN(sck_in), .O_TX_SELECT(txsel), .O_RECEIVE_ENABLE(rxen),
    .O_CLOCK_SELECT(csel), .O_COMM_SYNC(csync), .I_PORT_FIVE_PIN(p5pin), .I_PORT_FIVE_OUT(p5out),
    .I_PORT_FIVE_OUT_EN(p5en), .O_PORT_FIVE_PIN(p5drv), .O_PORT_FIVE_PIN_OE(p5oe), .O_WAKEUP_INPUT(wake),
    .O_ADC_EXTERNAL_TRIGGER(adc));
  ppfs_far_side u_far (.i_oe(oe2), .i_drv(drv2), .i_board(board), .o_pin(pin2));
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  // Next edge with ready high, bounded
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge clk);
    while (hready !== 1'b1)
    begin
      n++;
      if (n > 20)
      begin
        err_total++;
        end_sim;
      end
      @(posedge clk);
    end
  endtask : wait_rdy
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    haddr <= {24'h00_0000, a};
    hwrite <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    wait_rdy;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
  endtask : wr
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    haddr <= {24'h00_0000, a};
    hwrite <= 1'b0;
    htrans <= HTRANS_NONSEQ;
    wait_rdy;
    htrans <= 2'h0;
    wait_rdy;
    `CHK(hrdata, e)
  endtask : chk_rd
  // Registered pins need two edges after a write
  task automatic settle;
    repeat (3) @(posedge clk);
  endtask : settle
  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    foreach (regs[i])
      chk_rd(regs[i], 32'h0000_0000);
    chk_rd(OFS_PORT_TWO_DATA_REG, PDR_UPPER_ONES | 32'h0000_0005);
    chk_rd(OFS_PORT_FIVE_DATA, 32'h0000_00B4);
    `CHK({hresp, oe2}, 4'h0)
    $display("test reset done");
    wr(OFS_PORT_TWO_DIRECTION_REG, 32'h0000_0007);
    wr(OFS_PORT_TWO_DATA_REG, 32'h0000_0002);
    settle;
    `CHK({oe2, drv2}, 6'h3A)
    chk_rd(OFS_PORT_TWO_DATA_REG, PDR_UPPER_ONES | 32'h0000_0002);
    wr(OFS_PORT_TWO_DIRECTION_REG, 32'h0000_0004);
    settle;
    chk_rd(OFS_PORT_TWO_DATA_REG, PDR_UPPER_ONES | 32'h0000_0001);
    wr(OFS_PORT_TWO_DIRECTION_REG, 32'h0000_0007);
    $display("test general port done");
    wr(OFS_PORT_MODE_REG_ONE, 32'h0000_0001 << BIT_TX_SELECT);
    wr(OFS_SERIAL_CONTROL_REG, 32'h0000_0001 << BIT_RECEIVE_ENABLE);
    txd <= 1'b1;
    settle;
    `CHK({txsel, rxen, oe2[2:1], drv2[2], rxd}, 6'h3A)
    txd <= 1'b0;
    settle;
    `CHK(drv2[2], 1'b0)
    wr(OFS_PORT_MODE_REG_ONE, 32'h0000_0000);
    wr(OFS_SERIAL_CONTROL_REG, 32'h0000_0000);
    settle;
    `CHK({txsel, rxen, oe2, rxd}, 6'h0F)
    $display("test override done");
    // Every clock-select and mode combination
    for (int m = 0; m < 8; m++)
    begin
      // Serial clock low in one case so the routed level is visible
      sck <= 1'(m != 2);
      wr(OFS_SERIAL_CONTROL_REG, 32'(m >> 1));
      wr(OFS_SERIAL_MODE_REG, 32'(m & 1) << BIT_COMM_MODE);
      settle;
      `CHK({csel, csync}, 3'(m))
      `CHK(oe2[0], 1'(m < 4))
      `CHK(m < 4 ? drv2[0] : sck_in, 1'(m != 0 && m != 2))
    end
    $display("test clock pin done");
    wr(OFS_PORT_FIVE_MODE_REG, 32'h0000_00FC);
    settle;
    `CHK({wake, adc}, 5'h1B)
    `CHK({p5oe, p5drv[6]}, 3'h2)
    chk_rd(OFS_PORT_FIVE_MODE_REG, 32'h0000_00FC);
    wr(OFS_PORT_FIVE_MODE_REG, 32'h0000_0000);
    settle;
    `CHK({wake, p5oe, p5drv}, 8'h0E)
    $display("test port five done");
    end_sim;
  end
endmodule : tb
